//--- verilog/rbcr_pkg.sv
package rbcr_pkg;

    // Reference clock runs at this multiple of the bit rate
    localparam int unsigned REF_PER_BIT   = 128;
    localparam int unsigned CHAIN_STAGES  = 7;

    // Clock period in picoseconds
    localparam int unsigned CLK_PERIOD_PS = 10000;

    // Bit rates reachable by halving the base rate
    localparam int unsigned BAUD_MAX      = 1200;
    localparam int unsigned BAUD_MIN      = 150;
    localparam int unsigned BAUD_STEPS    = 4;

    // Values after reset
    localparam logic [6:0] CHAIN_RESET    = 7'h00;
    localparam logic       PULSE_IDLE     = 1'b1;
    localparam logic       SAMPLE_RESET   = 1'b0;

    // Count added by the first stage and by the second stage
    localparam logic [6:0] STEP_FIRST     = 7'h01;
    localparam logic [6:0] STEP_SECOND    = 7'h02;

endpackage

//--- verilog/rbcr_corr_if.sv
`timescale 1ns/1ps
`default_nettype none

// Correction pulses between the phase detector and the divide chain
interface rbcr_corr_if;
    logic rx_data;
    logic final_stage;
    logic transition;
    logic advance_n;
    logic retard_n;
    logic advance_end;

    modport detector (
        input  rx_data,
        input  final_stage,
        output transition,
        output advance_n,
        output retard_n,
        output advance_end
    );

    modport chain (
        output rx_data,
        output final_stage,
        input  transition,
        input  advance_n,
        input  retard_n,
        input  advance_end
    );
endinterface

`default_nettype wire

//--- verilog/rbcr_phase_detect.sv
`timescale 1ns/1ps
`default_nettype none

module rbcr_phase_detect (
    // Clock and synchronous reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // Correction pulses
    rbcr_corr_if.detector     corr
);

    logic transition_detector_flop;
    logic advance_pulse_flop;
    logic retard_pulse_flop;
    logic advance_prev;

    // Transition pulse from the sampled data
    assign corr.transition  = corr.rx_data ^ transition_detector_flop;
    assign corr.advance_n   = advance_pulse_flop;
    assign corr.retard_n    = retard_pulse_flop;
    assign corr.advance_end = advance_pulse_flop & ~advance_prev;

    // Data sample on each reference edge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            transition_detector_flop <= rbcr_pkg::SAMPLE_RESET;
        end else begin
            transition_detector_flop <= corr.rx_data;
        end
    end

    // Advance pulse only when the recovered clock is late
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            advance_pulse_flop <= rbcr_pkg::PULSE_IDLE;
            advance_prev       <= rbcr_pkg::PULSE_IDLE;
        end else begin
            // Clear on coincidence, set again next edge
            advance_pulse_flop <= ~(corr.transition & corr.final_stage);
            advance_prev       <= advance_pulse_flop;
        end
    end

    // Retard pulse on every transition
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            retard_pulse_flop <= rbcr_pkg::PULSE_IDLE;
        end else begin
            retard_pulse_flop <= ~corr.transition;
        end
    end

endmodule

`default_nettype wire

//--- verilog/rbcr_top.sv
`timescale 1ns/1ps
`default_nettype none

module rbcr_top #(
    parameter int unsigned STAGES = rbcr_pkg::CHAIN_STAGES
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic nrst,
    // Demodulated receive data and phase strap
    input  wire logic rx_data,
    input  wire logic phase_invert,
    // Recovered bit timing
    output var  logic bit_clk_a,
    output var  logic bit_clk_b,
    output var  logic retime_clk
);

    logic [1:0]        rst_pipe;
    logic              rst;
    logic [1:0]        rx_sync;
    logic [1:0]        strap_sync;
    logic [STAGES-1:0] divide_chain;
    logic [STAGES-1:0] next_chain;
    logic [STAGES-1:0] step;
    logic              first_divide_stage;
    logic              second_divide_stage;
    logic              final_divide_stage;

    localparam logic [STAGES-1:0] STEP_ONE =
        STAGES'(rbcr_pkg::STEP_FIRST);
    localparam logic [STAGES-1:0] STEP_TWO =
        STAGES'(rbcr_pkg::STEP_SECOND);

    rbcr_corr_if corr ();

    // Reset release through two flip-flops
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rst = ~rst_pipe[1];

    // Two-stage synchronisers for the pins
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rx_sync    <= 2'h0;
            strap_sync <= 2'h0;
        end else begin
            rx_sync    <= {rx_sync[0], rx_data};
            strap_sync <= {strap_sync[0], phase_invert};
        end
    end

    assign corr.rx_data     = rx_sync[1];
    assign corr.final_stage = final_divide_stage;

    rbcr_phase_detect u_detect (
        .ref_clk (ref_clk),
        .rst     (rst),
        .corr    (corr)
    );

    // Stage views of the chain
    assign first_divide_stage  = divide_chain[0];
    assign second_divide_stage = divide_chain[1];
    assign final_divide_stage  = divide_chain[STAGES-1];

    // First stage steps unless held; advance steps the second stage
    always_comb begin
        step = '0;
        if (corr.retard_n) begin
            step = step + STEP_ONE;
        end
        if (corr.advance_end) begin
            step = step + STEP_TWO;
        end
        next_chain = divide_chain + step;
    end

    // Divide chain, loaded with next_chain on each reference edge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            divide_chain <= STAGES'(rbcr_pkg::CHAIN_RESET);
        end else begin
            divide_chain <= next_chain;
        end
    end

    // Bit timing outputs, strap-selected phase on bit_clk_a and bit_clk_b only
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bit_clk_a  <= 1'b0;
            bit_clk_b  <= 1'b0;
            retime_clk <= 1'b1;
        end else begin
            bit_clk_a  <= final_divide_stage ^ strap_sync[1];
            bit_clk_b  <= final_divide_stage ^ strap_sync[1];
            retime_clk <= ~final_divide_stage;
        end
    end

endmodule

`default_nettype wire

//--- tb/rbcr_props.sv
`timescale 1ns/1ps
`default_nettype none
module rbcr_props (
    // Watched ports
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic rx_data,
    input wire logic phase_invert,
    input wire logic bit_clk_a,
    input wire logic bit_clk_b,
    input wire logic retime_clk
);
    logic [7:0] cnt, calm, up;
    logic       prev, seen, ret_f, adv_f, tog, mid;
    assign tog = retime_clk != prev;
    assign mid = calm == 8'hFF && seen && cnt > 8'h07 && cnt < 8'h29;
    // Half period length and quiet time on the data line
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            {cnt, calm, up, prev, seen, ret_f, adv_f} <= 28'h0000008;
        end else begin
            prev <= retime_clk;
            seen <= seen | tog;
            cnt <= tog ? 8'h01 : cnt + 8'h01;
            up <= (up == 8'hFF) ? up : up + 8'h01;
            calm <= $changed(rx_data) ? 8'h00 : (calm == 8'hFF) ? calm : calm + 8'h01;
            ret_f <= !tog && (ret_f || ($changed(rx_data) && mid && retime_clk));
            adv_f <= !tog && (adv_f || ($changed(rx_data) && mid && !retime_clk));
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    property p_dual; bit_clk_a == bit_clk_b; endproperty
    a_dual: assert property (p_dual) else $error("bit clocks differ");
    property p_phase; $stable(phase_invert)[*6] ##0 (up > 8'h0F) |->
        bit_clk_a == (retime_clk ~^ phase_invert); endproperty
    a_phase: assert property (p_phase) else $error("phase wrong");
    property p_reset; disable iff (1'b0)
        !nrst ##1 !nrst |-> !bit_clk_a && retime_clk;
    endproperty
    a_reset: assert property (p_reset) else $error("reset value");
    property p_half; seen && tog |-> cnt inside {[8'h3F:8'h41]}; endproperty
    a_half: assert property (p_half) else $error("half out of range");
    property p_nominal; seen && tog && calm == 8'hFF |-> cnt == 8'h40;
    endproperty
    a_nominal: assert property (p_nominal) else $error("half not 64");
    property p_retard; tog && ret_f |-> cnt == 8'h41; endproperty
    a_retard: assert property (p_retard) else $error("no retard");
    property p_advance; tog && adv_f |-> cnt == 8'h3F; endproperty
    a_advance: assert property (p_advance) else $error("no advance");
    property p_live; up > 8'h07 |-> ##[1:66] $changed(retime_clk); endproperty
    a_live: assert property (p_live) else $error("chain stuck");
    c_retard: cover property (tog && ret_f);
    c_advance: cover property (tog && adv_f);
    c_invert: cover property (phase_invert && tog);
endmodule
bind rbcr_top rbcr_props chk (.ref_clk, .nrst, .rx_data, .phase_invert,
    .bit_clk_a, .bit_clk_b, .retime_clk);
`default_nettype wire

//--- tb/rbcr_rx_equip.sv
`timescale 1ns/1ps
`default_nettype none
module rbcr_rx_equip (
    // Clock and recovered timing
    input  wire logic       ref_clk,
    input  wire logic       bit_clk,
    // Last half period length and edges seen
    output var  logic [7:0] half,
    output var  int         toggles
);
    logic [7:0] run = 8'h00, last = 8'h00;
    logic       prev = 1'b0;
    int         count = 0;
    assign half = last;
    assign toggles = count;
    always @(posedge ref_clk) begin
        prev <= bit_clk;
        run <= (bit_clk != prev) ? 8'h01 : run + 8'h01;
        if (bit_clk != prev) begin
            last <= run;
            count <= count + 1;
        end
    end
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk = 1'b0, nrst = 1'b1, rx_data = 1'b0, phase_invert = 1'b0;
    logic bit_clk_a, bit_clk_b, retime_clk;
    logic [7:0] half;
    int toggles, failures = 0, samples_checked = 0, cycles = 0;
    always #5 ref_clk = ~ref_clk;
    rbcr_top uut (.ref_clk, .nrst, .rx_data, .phase_invert, .bit_clk_a,
        .bit_clk_b, .retime_clk);
    rbcr_rx_equip eq (.ref_clk, .bit_clk(bit_clk_a), .half, .toggles);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (failures == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic next_half;
        int n;
        n = toggles;
        while (toggles == n) @(posedge ref_clk);
    endtask
    task automatic do_reset;
        nrst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check({7'h00, bit_clk_a}, 8'h00);
        check({7'h00, retime_clk}, 8'h01);
        nrst <= 1'b1;
    endtask
    // Data edge in mid half of the given level, then measure that half
    task automatic nudge(input logic lvl, input logic [7:0] exp);
        repeat (300) @(posedge ref_clk);
        next_half();
        while (bit_clk_a !== lvl) next_half();
        repeat (20) @(posedge ref_clk);
        rx_data <= ~rx_data;
        next_half();
        check(half, exp);
    endtask
    initial begin
        do_reset();
        repeat (300) @(posedge ref_clk);
        next_half();
        check(half, 8'h40);
        nudge(1'b0, 8'h41);
        nudge(1'b1, 8'h3F);
        phase_invert <= 1'b1;
        repeat (10) @(posedge ref_clk);
        check({7'h00, bit_clk_a}, {7'h00, retime_clk});
        check({7'h00, bit_clk_b}, {7'h00, bit_clk_a});
        nudge(1'b1, 8'h41);
        repeat (12) begin
            repeat (128) @(posedge ref_clk);
            rx_data <= ~rx_data;
        end
        do_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
